// ### sdmbs_top.sv
// Mode word register, burst column sequencing and read latency of the memory device
// Summary of operation
// - Mode word holds its value until the next mode load command.
// - Mode word fields: length, order, latency, operating mode, write mode, spare bit.
// - Lengths 1, 2, 4, 8 in both orders; full page only sequential.
// - Upper column bits pick an aligned block; low bits start; wrap inside it.
// - Full page starts at given column, steps through 256 columns, wraps to zero.
// - Length one accesses only the given column; order bit ignored.
// - Sequential: each offset is previous plus one, modulo burst length.
// - Interleaved: offset of beat k is start offset xor k.
// - Latency codes 001, 010, 011 give one, two, three clocks.
// - Read at edge n drives data after edge n+m-1, valid by n+m.
// - Normal operation only with both operating mode bits zero.
// - Write mode bit one makes writes single-location; reads keep programmed length.
// - Mode load captures address bits 10..0 as the new mode word.
`timescale 1ns/100ps
module sdmbs_top
    import sdmbs_pkg::*;
#(
    parameter int DW = DATA_W,
    parameter int COLS = PAGE_COLS,
    parameter int WBUF_DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Command pins, sampled on the rising edge
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic [MODE_W-1:0] i_addr,
    // Data pins, split into input, output and output enable
    input wire logic [DW-1:0] i_dq,
    output logic [DW-1:0] o_dq,
    output logic o_dq_oe,
    // Status
    output logic [MODE_W-1:0] o_mode_word,
    output logic o_burst_active,
    output logic o_wr_ready
);
    localparam int FW = COL_W + DW;

    // Command decode from the pins, same clock as the pins are launched on
    logic sel;
    logic cmd_load, cmd_rd, cmd_wr, cmd_term;
    assign sel = !i_cs_n;
    assign cmd_load = sel && ({i_ras_n, i_cas_n, i_we_n} == CMD_MODE_LOAD);
    assign cmd_rd = sel && ({i_ras_n, i_cas_n, i_we_n} == CMD_READ);
    assign cmd_wr = sel && ({i_ras_n, i_cas_n, i_we_n} == CMD_WRITE);
    assign cmd_term = sel && ({i_ras_n, i_cas_n, i_we_n} == CMD_TERM);

    // Mode word register
    logic [MODE_W-1:0] mode_q, mode_d;

    // Only a load command changes the word; it is otherwise held
    always_comb begin
        mode_d = mode_q;
        if (cmd_load) begin
            mode_d = i_addr;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_q <= MODE_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Field decode of the stored word
    logic [2:0] bl_code;
    logic order_ilv;
    logic [2:0] lat_code;
    logic [1:0] opm;
    logic wsingle;
    logic normal;
    assign bl_code = mode_q[BL_MSB:BL_LSB];
    assign order_ilv = mode_q[ORDER_BIT];
    assign lat_code = mode_q[LAT_MSB:LAT_LSB];
    assign opm = mode_q[OPM_MSB:OPM_LSB];
    assign wsingle = mode_q[WSINGLE_BIT];
    assign normal = opm == OPM_NORMAL;

    // Burst sequencer state
    sdmbs_state_t state_q, state_d;
    logic [COL_W-1:0] start_q, start_d;
    logic [COL_W-1:0] beat_q, beat_d;
    logic [2:0] len_q, len_d;
    logic ilv_q, ilv_d;

    // Current beat as seen by the column generator
    sdmbs_burst_if bif ();
    logic beat_rd, beat_wr;
    logic [COL_W-1:0] beat_mask;

    sdmbs_col_gen u_col_gen (
        .b(bif.gen)
    );

    // A new read or write starts a burst at once, so beat zero is live this cycle
    always_comb begin
        bif.start_col = start_q;
        bif.beat = beat_q;
        bif.len_code = len_q;
        bif.interleave = ilv_q;
        beat_rd = 1'b0;
        beat_wr = 1'b0;
        if (normal && (cmd_rd || cmd_wr)) begin
            bif.start_col = i_addr[COL_W-1:0];
            bif.beat = '0;
            bif.len_code = (cmd_wr && wsingle) ? BL_1 : bl_code;
            bif.interleave = order_ilv;
            beat_rd = cmd_rd;
            beat_wr = cmd_wr;
        end else if (state_q != ST_IDLE && !cmd_term) begin
            beat_rd = state_q == ST_READ;
            beat_wr = state_q == ST_WRITE;
        end
        beat_mask = sdmbs_len_mask(bif.len_code);
    end

    // Step the beat index; the last beat or a terminate returns to idle
    always_comb begin
        state_d = state_q;
        start_d = start_q;
        beat_d = beat_q;
        len_d = len_q;
        ilv_d = ilv_q;
        if (beat_rd || beat_wr) begin
            start_d = bif.start_col;
            len_d = bif.len_code;
            ilv_d = bif.interleave;
            if (bif.beat == beat_mask) begin
                state_d = ST_IDLE;
                beat_d = '0;
            end else begin
                state_d = beat_rd ? ST_READ : ST_WRITE;
                beat_d = bif.beat + 1'b1;
            end
        end else if (cmd_term || !normal) begin
            state_d = ST_IDLE;
            beat_d = '0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            start_q <= '0;
            beat_q <= '0;
            len_q <= BL_1;
            ilv_q <= 1'b0;
        end else begin
            state_q <= state_d;
            start_q <= start_d;
            beat_q <= beat_d;
            len_q <= len_d;
            ilv_q <= ilv_d;
        end
    end

    // Write path: captured data waits in the buffer until the array port is free
    logic wf_valid, wf_ready;
    logic [FW-1:0] wf_data;
    logic wf_pop;

    // Reads own the array port, so the buffer drains only between read beats
    assign wf_pop = !beat_rd;

    sdmbs_fifo #(
        .W(FW),
        .DEPTH(WBUF_DEPTH)
    ) u_wbuf (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(beat_wr),
        .o_in_ready(o_wr_ready),
        .i_in_data({bif.col, i_dq}),
        .o_out_valid(wf_valid),
        .i_out_ready(wf_pop),
        .o_out_data(wf_data)
    );
    assign wf_ready = wf_valid && wf_pop;

    // Row storage of one open page, written from the buffer
    logic [DW-1:0] mem_q [COLS];

    always_ff @(posedge i_clk) begin
        if (wf_ready) begin
            mem_q[wf_data[FW-1:DW]] <= wf_data[DW-1:0];
        end
    end

    // Read latency delay line: stage k holds beats launched k+1 cycles ago
    logic [1:0] pv_q, pv_d;
    logic [COL_W-1:0] pc_q [2];
    logic [COL_W-1:0] pc_d [2];
    logic out_v;
    logic [COL_W-1:0] out_col;

    always_comb begin
        pv_d = {pv_q[0], beat_rd};
        pc_d[0] = bif.col;
        pc_d[1] = pc_q[0];
        // Reserved latency codes fall back to the longest latency
        unique case (lat_code)
            LAT_1: begin
                out_v = beat_rd;
                out_col = bif.col;
            end
            LAT_2: begin
                out_v = pv_q[0];
                out_col = pc_q[0];
            end
            default: begin
                out_v = pv_q[1];
                out_col = pc_q[1];
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pv_q <= '0;
            pc_q[0] <= '0;
            pc_q[1] <= '0;
        end else begin
            pv_q <= pv_d;
            pc_q[0] <= pc_d[0];
            pc_q[1] <= pc_d[1];
        end
    end

    // Output stage: launched at edge n+m-1 so data is valid by edge n+m
    logic [DW-1:0] dq_q, dq_d;
    logic oe_q, oe_d;

    always_comb begin
        oe_d = out_v;
        dq_d = out_v ? mem_q[out_col] : dq_q;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dq_q <= '0;
            oe_q <= 1'b0;
        end else begin
            dq_q <= dq_d;
            oe_q <= oe_d;
        end
    end

    assign o_dq = dq_q;
    assign o_dq_oe = oe_q;
    assign o_mode_word = mode_q;
    assign o_burst_active = state_q != ST_IDLE;
endmodule

// ### sdmbs_pkg.sv
// Shared constants, field layout and types of the mode and burst sequencer
package sdmbs_pkg;
    // Geometry
    localparam int MODE_W = 11;
    localparam int COL_W = 8;
    localparam int DATA_W = 32;
    localparam int PAGE_COLS = 256;
    localparam int FIFO_DEPTH = 16;
    // Mode word field positions
    localparam int BL_LSB = 0;
    localparam int BL_MSB = 2;
    localparam int ORDER_BIT = 3;
    localparam int LAT_LSB = 4;
    localparam int LAT_MSB = 6;
    localparam int OPM_LSB = 7;
    localparam int OPM_MSB = 8;
    localparam int WSINGLE_BIT = 9;
    localparam int SPARE_BIT = 10;
    // Value of the mode word after reset
    localparam logic [MODE_W-1:0] MODE_RESET = 11'h000;
    // Burst length codes
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    // Read latency codes
    localparam logic [2:0] LAT_1 = 3'h1;
    localparam logic [2:0] LAT_2 = 3'h2;
    localparam logic [2:0] LAT_3 = 3'h3;
    localparam logic [1:0] OPM_NORMAL = 2'h0;
    // Command codes on {ras_n, cas_n, we_n} with chip select low
    localparam logic [2:0] CMD_MODE_LOAD = 3'h0;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_TERM = 3'h6;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b100
    } sdmbs_state_t;

    // Offset mask of a burst: the low column bits that move inside the block
    function automatic logic [COL_W-1:0] sdmbs_len_mask(input logic [2:0] code);
        logic [COL_W-1:0] m;
        m = 8'h00;
        case (code)
            BL_2: m = 8'h01;
            BL_4: m = 8'h03;
            BL_8: m = 8'h07;
            BL_PAGE: m = 8'hff;
            default: m = 8'h00;
        endcase
        return m;
    endfunction
endpackage

// ### sdmbs_burst_if.sv
// Carrier between the burst sequencer and the column generator
`timescale 1ns/100ps
interface sdmbs_burst_if;
    logic [7:0] start_col;
    logic [7:0] beat;
    logic [2:0] len_code;
    logic interleave;
    logic [7:0] col;
    modport seq (output start_col, beat, len_code, interleave, input col);
    modport gen (input start_col, beat, len_code, interleave, output col);
endinterface

// ### sdmbs_col_gen.sv
// Column address of one burst beat from start column, beat index, length and order
`timescale 1ns/100ps
module sdmbs_col_gen
    import sdmbs_pkg::*;
(
    // Burst description in, column out
    sdmbs_burst_if.gen b
);
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] offset;

    // Block bits stay fixed, offset bits step and wrap inside the block
    always_comb begin
        mask = sdmbs_len_mask(b.len_code);
        if (b.interleave && b.len_code != BL_PAGE) begin
            offset = b.start_col ^ b.beat;
        end else begin
            offset = b.start_col + b.beat;
        end
        b.col = (b.start_col & ~mask) | (offset & mask);
    end
endmodule

// ### sdmbs_fifo.sv
// Parameterised first-in first-out buffer with valid and ready on both sides
`timescale 1ns/100ps
module sdmbs_fifo #(
    parameter int W = 40,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Filling side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    // Draining side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    // Depth must be a power of two so the pointers wrap by themselves
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign o_in_ready = cnt_q != (AW+1)'(DEPTH);
    assign o_out_valid = cnt_q != '0;
    assign o_out_data = mem_q[rd_q];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Pointer and fill count update
    always_comb begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage needs no reset; empty entries are never read
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end
endmodule

// ### sdmbs_asserts.sv
// Concurrent checks on the sequencer pins
`timescale 1ns/100ps
module sdmbs_asserts
    import sdmbs_pkg::*;
#(
    parameter int DW = 32
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Command pins
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic [MODE_W-1:0] i_addr,
    // Device outputs
    input wire logic [DW-1:0] o_dq,
    input wire logic o_dq_oe,
    input wire logic [MODE_W-1:0] o_mode_word,
    input wire logic o_burst_active
);
    logic ld;
    logic rd;
    logic fresh;
    logic [2:0] lat;
    // Decode; fresh is a normal read with no burst active and the output enable low
    assign ld = !i_cs_n && {i_ras_n, i_cas_n, i_we_n} == CMD_MODE_LOAD;
    assign rd = !i_cs_n && {i_ras_n, i_cas_n, i_we_n} == CMD_READ;
    assign lat = o_mode_word[LAT_MSB:LAT_LSB];
    assign fresh = rd && o_mode_word[8:7] == OPM_NORMAL && !o_burst_active && !o_dq_oe;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Mode word
    chk_mode_load: assert property (ld |=> o_mode_word == $past(i_addr))
        else $error("mode word not captured");
    chk_mode_hold: assert property (!ld |=> $stable(o_mode_word))
        else $error("mode word moved");
    // Latency and beat counts
    chk_lat_one: assert property (fresh && lat == LAT_1 |=> o_dq_oe)
        else $error("latency one missed");
    chk_lat_two: assert property (fresh && lat == LAT_2 |=> !o_dq_oe ##1 o_dq_oe)
        else $error("latency two missed");
    chk_single_beat: assert property (fresh && lat == LAT_3 && o_mode_word[2:0] == BL_1
        |=> !o_dq_oe [*2] ##1 o_dq_oe ##1 !o_dq_oe) else $error("single beat wrong");
    chk_len_four: assert property (fresh && lat == LAT_1 && o_mode_word[2:0] == BL_4
        |=> o_dq_oe [*4] ##1 !o_dq_oe) else $error("four beats wrong");
    chk_test_refused: assert property (rd && o_mode_word[8:7] != OPM_NORMAL
        |=> !o_burst_active [*3]) else $error("read ran in test mode");
    chk_dq_hold: assert property (!o_dq_oe |-> $stable(o_dq))
        else $error("data moved while idle");
    // Main scenarios
    cover property (ld);
    cover property (fresh && lat == LAT_3);
    cover property (fresh && o_mode_word[2:0] == BL_PAGE);
endmodule
bind sdmbs_top sdmbs_asserts #(.DW(DW)) sdmbs_asserts_i (.i_clk(i_clk), .i_rst(i_rst),
    .i_cs_n(i_cs_n), .i_ras_n(i_ras_n), .i_cas_n(i_cas_n), .i_we_n(i_we_n), .i_addr(i_addr),
    .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_mode_word(o_mode_word), .o_burst_active(o_burst_active));

// ### sdmbs_ctl.sv
// Behavioural memory controller driving the device command and data pins
`timescale 1ns/100ps
module sdmbs_ctl (
    // Clock
    input wire logic i_clk,
    // Command, address and write data
    output logic o_cs_n,
    output logic [2:0] o_cmd,
    output logic [10:0] o_addr,
    output logic [31:0] o_dq
);
    // Start deselected
    initial begin
        o_cs_n = 1'b1;
        o_cmd = 3'h7;
        o_addr = 11'h000;
        o_dq = 32'h0;
    end
    // One slot per call; deselected slots scramble the address so stale values never help
    task automatic drive(input logic sel, input logic [2:0] c, input logic [10:0] a,
        input logic [31:0] d);
        @(negedge i_clk);
        o_cs_n = !sel;
        o_cmd = sel ? c : 3'h7;
        o_addr = sel ? a : ~o_addr;
        o_dq = d;
    endtask
endmodule

// ### sdmbs_top_tb.sv
// Self-checking bench of the mode word and burst sequencer
`timescale 1ns/100ps
module sdmbs_top_tb;
    import sdmbs_pkg::*;
    // Pins, reference page and expected read data
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic cs_n, oe, busy, wr_rdy;
    logic [2:0] cmd;
    logic [10:0] addr, mode, cur;
    logic [31:0] dq_w, dq_r, d;
    logic [31:0] mem [256];
    logic [31:0] exp_q [$];
    logic [15:0] lfsr = 16'h03a8;
    int failures = 0;
    int checks_done = 0;
    logic [10:0] t_mode [10] = '{11'h010, 11'h038, 11'h021, 11'h029, 11'h012, 11'h01a,
        11'h033, 11'h02b, 11'h037, 11'h01f};
    logic [7:0] t_col [10] = '{8'h05, 8'h06, 8'h03, 8'h0c, 8'h06, 8'h05, 8'h0d, 8'h0b, 8'hfe,
        8'h07};
    int t_n [10] = '{1, 1, 2, 2, 4, 4, 8, 8, 4, 3};
    always #2 i_clk = ~i_clk;
    // Controller model and device
    sdmbs_ctl sdmbs_ctl_i (.i_clk(i_clk), .o_cs_n(cs_n), .o_cmd(cmd), .o_addr(addr),
        .o_dq(dq_w));
    sdmbs_top sdmbs_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_ras_n(cmd[2]),
        .i_cas_n(cmd[1]), .i_we_n(cmd[0]), .i_addr(addr), .i_dq(dq_w), .o_dq(dq_r),
        .o_dq_oe(oe), .o_mode_word(mode), .o_burst_active(busy), .o_wr_ready(wr_rdy));
    task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", s, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("counts: %0d checks, %0d failures", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    function automatic logic [15:0] lfsr_step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Column of beat k; a full page runs sequential whatever the order bit says
    function automatic logic [7:0] col_of(input logic [7:0] s, input int k);
        logic [7:0] m;
        logic [7:0] o;
        m = cur[2:0] == 3'h1 ? 8'h01 : cur[2:0] == 3'h2 ? 8'h03 : cur[2:0] == 3'h3 ? 8'h07 :
            cur[2:0] == 3'h7 ? 8'hff : 8'h00;
        o = cur[3] && m != 8'hff ? s ^ 8'(k) : s + 8'(k);
        return (s & ~m) | (o & m);
    endfunction
    task automatic idle(input int n);
        repeat (n) sdmbs_ctl_i.drive(1'b0, 3'h7, 11'h000, ~dq_w);
    endtask
    // Four slots first so a pending latency-three beat is never missed
    task automatic drain();
        int i;
        idle(4);
        for (i = 0; i < 600 && (busy !== 1'b0 || oe !== 1'b0); i++) idle(1);
        if (i == 600) begin
            failures++;
            $display("unexpected drain: expected idle, seen busy");
            give_verdict();
        end
    endtask
    task automatic ld(input logic [10:0] w);
        cur = w;
        sdmbs_ctl_i.drive(1'b1, CMD_MODE_LOAD, w, ~dq_w);
        idle(2);
        check("mode word", 32'(w), 32'(mode));
    endtask
    task automatic wr(input logic [7:0] s, input int n);
        for (int k = 0; k < n; k++) begin
            lfsr = lfsr_step(lfsr);
            d = {lfsr, ~lfsr};
            sdmbs_ctl_i.drive(k == 0, CMD_WRITE, {3'h0, s}, d);
            if (cur[8:7] == 2'h0 && (k == 0 || !cur[9])) mem[col_of(s, k)] = d;
        end
        idle(4);
    endtask
    task automatic rd(input logic [7:0] s, input int n, input logic stop);
        for (int k = 0; k < n; k++) begin
            if (cur[8:7] == 2'h0) exp_q.push_back(mem[col_of(s, k)]);
        end
        sdmbs_ctl_i.drive(1'b1, CMD_READ, {3'h0, s}, ~dq_w);
        idle(n - 1);
        if (stop) sdmbs_ctl_i.drive(1'b1, CMD_TERM, 11'h000, ~dq_w);
        drain();
        check("beats left", 32'h0, 32'(exp_q.size()));
        check("mode kept", 32'(cur), 32'(mode));
    endtask
    // Each driven beat takes the oldest expected word
    always @(negedge i_clk) begin
        if (oe === 1'b1 && exp_q.size() == 0) begin
            failures++;
            checks_done++;
            $display("unexpected beat: expected none, seen %h", dq_r);
        end else if (oe === 1'b1) begin
            check("read data", exp_q.pop_front(), dq_r);
        end
    end
    // Reset, fill, burst table, single-location writes, refused modes
    initial begin
        cur = 11'h000;
        repeat (12) @(posedge i_clk);
        @(negedge i_clk) i_rst = 1'b0;
        check("reset pins", 32'h1, 32'({mode, oe, busy, wr_rdy}));
        $display("done reset");
        ld(11'h033);
        wr(8'h00, 8);
        wr(8'h08, 8);
        ld(11'h021);
        wr(8'hff, 2);
        $display("done fill");
        for (int i = 0; i < 10; i++) begin
            ld(t_mode[i]);
            rd(t_col[i], t_n[i], t_mode[i][2:0] == BL_PAGE);
        end
        $display("done burst table");
        ld(11'h212);
        wr(8'h09, 4);
        rd(8'h08, 4, 1'b0);
        $display("done single write");
        ld(11'h092);
        wr(8'h00, 4);
        rd(8'h00, 4, 1'b0);
        ld(11'h112);
        rd(8'h00, 4, 1'b0);
        ld(11'h012);
        rd(8'h00, 4, 1'b0);
        $display("done refused modes");
        give_verdict();
    end
endmodule
